//--- dv/fast_ethernet_tx_line_coder_test.sv
// Self-checking bench for the transmit line coder.
`timescale 1ns/100ps
module fast_ethernet_tx_line_coder_test;
   import fetxc_pkg::*;
   localparam logic [4:0] CG [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
   logic        mclk = 1'b0, nrst = 1'b0, tx_err = 1'b0, go = 1'b0;
   logic        enc_bypass = 1'b0, scr_bypass = 1'b1;
   fetxc_cg_t   raw_cg = 5'h00;
   logic [3:0]  base = 4'h0, tx_nibble;
   logic        tx_en, nibble_take, line_tx_pair_p, line_tx_pair_n, nrzi_out;
   logic [2:0]  frame_state;
   logic [39:0] hist = '0, pat = '0, msk = '0;
   logic        prev_nrzi = 1'b0, last_pos = 1'b0, was_zero = 1'b1, seen = 1'b0;
   int          hits = 0, mlt_bad = 0, n_mismatch = 0, tests_run = 0;

   always #12.5 mclk = ~mclk;

   fetxc_mac_model u_fetxc_mac_model (.mclk(mclk), .nrst(nrst), .go(go), .base(base),
      .nibble_take(nibble_take), .tx_en(tx_en), .tx_nibble(tx_nibble));
   fetxc_coder u_fetxc_coder (.mclk(mclk), .nrst(nrst), .tx_nibble(tx_nibble), .tx_en(tx_en),
      .tx_err(tx_err), .raw_cg(raw_cg), .enc_bypass(enc_bypass), .scr_bypass(scr_bypass),
      .nibble_take(nibble_take), .frame_state(frame_state), .line_tx_pair_p(line_tx_pair_p),
      .line_tx_pair_n(line_tx_pair_n), .nrzi_out(nrzi_out));

   // A transition on the NRZI line is a one, so this recovers the scrambler output stream.
   always @(posedge mclk) begin
      prev_nrzi <= nrzi_out;
      hist <= {hist[38:0], nrzi_out ^ prev_nrzi};
      if ((hist & msk) === pat) hits <= hits + 1;
      if (!nrst) seen <= 1'b0;
      else begin
         if (line_tx_pair_p & line_tx_pair_n) mlt_bad <= mlt_bad + 1;
         if ((line_tx_pair_p | line_tx_pair_n) & was_zero & seen
             & (line_tx_pair_p == last_pos)) mlt_bad <= mlt_bad + 1;
         if (line_tx_pair_p | line_tx_pair_n) begin
            seen <= 1'b1;
            last_pos <= line_tx_pair_p;
         end
      end
      was_zero <= !(line_tx_pair_p | line_tx_pair_n);
   end

   task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Searches the recovered stream for a pattern in any phase over a fixed window.
   task automatic look(input string nm, input logic [39:0] p, input logic [39:0] m,
                       input logic g, input logic e, input int cyc);
      int h0;
      @(posedge mclk);
      pat <= p;
      msk <= m;
      @(posedge mclk);
      h0 = hits;
      go <= g;
      @(posedge mclk);
      go <= 1'b0;
      repeat (cyc) @(posedge mclk);
      chk(nm, {39'h0, e}, {39'h0, hits > h0});
   endtask : look

   task automatic t_start;
      look("start pair", {30'h0, 5'h18, 5'h11}, 40'h3ff, 1'b1, 1'b1, 80);
      $display("test start pair done");
   endtask : t_start

   task automatic t_frame(input logic [3:0] b, input logic err);
      logic [39:0] tail;
      tail = '0;
      for (int i = 0; i < 4; i++) tail = {tail[34:0], err ? 5'h04 : CG[b + 4'(i)]};
      tail = {tail[29:0], 5'h0d, 5'h07};
      @(posedge mclk);
      base <= b;
      tx_err <= err;
      look("frame tail", tail, 40'h3fffffff, 1'b1, 1'b1, 80);
      tx_err <= 1'b0;
      #1;
      chk("frame state", 40'h0, {37'h0, frame_state});
      look("idle fill", '1, '1, 1'b0, 1'b1, 45);
      $display("test frame %h done", b);
   endtask : t_frame

   task automatic t_scr;
      scr_bypass <= 1'b0;
      // Let scrambled bits reach the recovery window before counting.
      repeat (12) @(posedge mclk);
      look("scrambled idle", '1, '1, 1'b0, 1'b0, 60);
      scr_bypass <= 1'b1;
      $display("test scrambler done");
   endtask : t_scr

   task automatic t_byp;
      enc_bypass <= 1'b1;
      raw_cg <= 5'h15;
      look("raw group", {20'h0, {4{5'h15}}}, 40'hfffff, 1'b0, 1'b1, 40);
      enc_bypass <= 1'b0;
      $display("test coder bypass done");
   endtask : t_byp

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : final_report

   initial begin
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      t_start();
      for (int k = 0; k < 4; k++) t_frame(4'(4 * k), 1'b0);
      t_frame(4'h3, 1'b1);
      t_scr();
      t_byp();
      chk("line levels", 40'h0, 40'(mlt_bad));
      final_report();
   end

   // The tests need about 900 cycles; this bound only cuts a hang short.
   initial begin
      repeat (6000) @(posedge mclk);
      n_mismatch++;
      final_report();
   end
endmodule : fast_ethernet_tx_line_coder_test

//--- dv/fetxc_mac_model.sv
// Behavioural MAC that feeds one short frame of nibbles on request.
`timescale 1ns/100ps
module fetxc_mac_model (
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       go,
   input  wire logic [3:0] base,
   input  wire logic       nibble_take,
   output logic            tx_en,
   output logic [3:0]      tx_nibble
);
   logic [2:0] idx_q;
   // Two preamble nibbles lead, so only the last four data groups are known exactly.
   assign tx_nibble = (idx_q < 3'h2) ? 4'h5 : base + {1'b0, idx_q} - 4'h2;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tx_en <= 1'b0;
         idx_q <= 3'h0;
      end else if (go) begin
         tx_en <= 1'b1;
         idx_q <= 3'h0;
      end else if (tx_en && nibble_take) begin
         idx_q <= idx_q + 3'h1;
         if (idx_q == 3'h5) tx_en <= 1'b0;
      end
   end
endmodule : fetxc_mac_model

//--- rtl/fetxc_coder.sv
// Fast ethernet transmit path: 4B/5B coder, scrambler, NRZI and three-level split.
`timescale 1ns/100ps
`include "fetxc_regs.svh"
module fetxc_coder (
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic [3:0]       tx_nibble,
   input  wire logic             tx_en,
   input  wire logic             tx_err,
   input  wire fetxc_pkg::fetxc_cg_t raw_cg,
   input  wire logic             enc_bypass,
   input  wire logic             scr_bypass,
   output logic                  nibble_take,
   output logic [2:0]            frame_state,
   output logic                  line_tx_pair_p,
   output logic                  line_tx_pair_n,
   output logic                  nrzi_out
);
   import fetxc_pkg::*;

   fetxc_state_t st_q;
   fetxc_state_t st_d;
   logic [4:0]   shr_q;
   logic [4:0]   shr_d;
   logic [2:0]   bit_q;
   logic [2:0]   bit_d;
   fetxc_cg_t    cg;
   logic         last;
   logic         ser_bit;

   function automatic fetxc_cg_t data_cg(input logic [3:0] n);
      fetxc_cg_t c;
      case (n)
         4'h0:    c = 5'h1e;
         4'h1:    c = 5'h09;
         4'h2:    c = 5'h14;
         4'h3:    c = 5'h15;
         4'h4:    c = 5'h0a;
         4'h5:    c = 5'h0b;
         4'h6:    c = 5'h0e;
         4'h7:    c = 5'h0f;
         4'h8:    c = 5'h12;
         4'h9:    c = 5'h13;
         4'ha:    c = 5'h16;
         4'hb:    c = 5'h17;
         4'hc:    c = 5'h1a;
         4'hd:    c = 5'h1b;
         4'he:    c = 5'h1c;
         default: c = 5'h1d;
      endcase
      return c;
   endfunction : data_cg

   // One symbol slot is five mclk cycles, so mclk plays the 125 MHz bit clock role.
   assign last        = (bit_q == `FETXC_BIT_LAST);
   // The first two nibbles are consumed in the J and K slots, so the delimiters replace them.
   assign nibble_take = last && tx_en &&
                        (st_q == FETXC_IDLE || st_q == FETXC_SEND_J ||
                         st_q == FETXC_SEND_K || st_q == FETXC_DATA);

   always_comb begin
      st_d  = st_q;
      cg    = `FETXC_CG_IDLE;
      case (st_q)
         FETXC_IDLE: begin
            if (tx_en) begin
               st_d  = FETXC_SEND_J;
               cg    = `FETXC_CG_J;
            end
         end
         FETXC_SEND_J: begin
            st_d = FETXC_SEND_K;
            cg   = `FETXC_CG_K;
         end
         FETXC_SEND_K, FETXC_DATA: begin
            if (tx_en) begin
               st_d  = FETXC_DATA;
               // A MAC error mid-frame is flagged with halt instead of data.
               cg    = tx_err ? `FETXC_CG_HALT : data_cg(tx_nibble);
            end else begin
               st_d = FETXC_SEND_T;
               cg   = `FETXC_CG_T;
            end
         end
         FETXC_SEND_T: begin
            st_d = FETXC_SEND_R;
            cg   = `FETXC_CG_R;
         end
         FETXC_SEND_R: begin
            st_d = FETXC_IDLE;
         end
         default: begin
            st_d = FETXC_IDLE;
         end
      endcase
      if (enc_bypass) begin
         cg = raw_cg;
      end
      bit_d = last ? `FETXC_BIT_FIRST : bit_q + 3'h1;
      if (last) begin
         shr_d = cg;
      end else begin
         shr_d = {shr_q[3:0], 1'b0};
      end
      if (!last) begin
         st_d  = st_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_q  <= FETXC_IDLE;
         shr_q <= `FETXC_CG_IDLE;
         bit_q <= `FETXC_BIT_FIRST;
      end else begin
         st_q  <= st_d;
         shr_q <= shr_d;
         bit_q <= bit_d;
      end
   end

   assign ser_bit     = shr_q[4];
   assign frame_state = st_q;

   logic scr_bit;
   fetxc_scrambler #(
      .WIDTH (11)
   ) u_scr (
      .mclk   (mclk),
      .nrst   (nrst),
      .bypass (scr_bypass),
      .din    (ser_bit),
      .dout   (scr_bit)
   );

   fetxc_mlt3 u_mlt (
      .mclk           (mclk),
      .nrst           (nrst),
      .din            (scr_bit),
      .nrzi           (nrzi_out),
      .line_tx_pair_p (line_tx_pair_p),
      .line_tx_pair_n (line_tx_pair_n)
   );

   sequence s_fall_in_data;
      last && (st_q == FETXC_DATA) && !tx_en;
   endsequence
   sequence s_tr_pair;
      (st_q == FETXC_SEND_T) [*5] ##1 (st_q == FETXC_SEND_R) [*5];
   endsequence
   sequence s_start;
      last && (st_q == FETXC_IDLE) && tx_en;
   endsequence

   chk_end_delim: assert property (@(posedge mclk) disable iff (!nrst || enc_bypass)
      s_fall_in_data |=> s_tr_pair ##1 (st_q == FETXC_IDLE)) else $error("end delimiter wrong");
   chk_start_pair: assert property (@(posedge mclk) disable iff (!nrst || enc_bypass)
      s_start |=> shr_q == `FETXC_CG_J ##5 shr_q == `FETXC_CG_K) else $error("start pair wrong");
   chk_idle_fill: assert property (@(posedge mclk) disable iff (!nrst || enc_bypass)
      last && st_q == FETXC_IDLE && !tx_en |=> shr_q == `FETXC_CG_IDLE) else $error("idle missing");
   chk_data_code: assert property (@(posedge mclk) disable iff (!nrst || enc_bypass)
      last && st_q == FETXC_DATA && tx_en && !tx_err |=> shr_q == data_cg($past(tx_nibble)))
      else $error("data code wrong");
   chk_slot_len: assert property (@(posedge mclk) disable iff (!nrst)
      last |=> !last [*4] ##1 last) else $error("slot not five bits");
endmodule : fetxc_coder

//--- rtl/fetxc_mlt3.sv
// NRZI coder and three-level splitter that drives the line pair.
`timescale 1ns/100ps
module fetxc_mlt3 (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic din,
   output logic      nrzi,
   output logic      line_tx_pair_p,
   output logic      line_tx_pair_n
);
   import fetxc_pkg::*;
   logic       nrzi_q;
   logic       nrzi_d;
   fetxc_mlt_t mlt_q;
   fetxc_mlt_t mlt_d;
   logic       p_d;
   logic       n_d;
   always_comb begin
      nrzi_d = nrzi_q ^ din;
      mlt_d  = mlt_q;
      if (din) begin
         mlt_d = fetxc_mlt_t'(mlt_q + 2'h1);
      end
      p_d = (mlt_d == FETXC_MLT_PLUS);
      n_d = (mlt_d == FETXC_MLT_MINUS);
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         nrzi_q         <= 1'b0;
         mlt_q          <= FETXC_MLT_ZERO_UP;
         line_tx_pair_p <= 1'b0;
         line_tx_pair_n <= 1'b0;
      end else begin
         nrzi_q         <= nrzi_d;
         mlt_q          <= mlt_d;
         line_tx_pair_p <= p_d;
         line_tx_pair_n <= n_d;
      end
   end
   assign nrzi = nrzi_q;
   chk_pair_exclusive: assert property (@(posedge mclk) disable iff (!nrst)
      !(line_tx_pair_p && line_tx_pair_n)) else $error("both line halves driven");
   chk_mlt_hold: assert property (@(posedge mclk) disable iff (!nrst)
      !din |=> $stable(mlt_q)) else $error("level moved on a zero");
   chk_nrzi_toggle: assert property (@(posedge mclk) disable iff (!nrst)
      din |=> nrzi_q != $past(nrzi_q)) else $error("nrzi missed a toggle");
endmodule : fetxc_mlt3

//--- rtl/fetxc_pkg.sv
// Types shared by the fast ethernet transmit line coder.
package fetxc_pkg;
   typedef enum logic [2:0] {
      FETXC_IDLE,
      FETXC_SEND_J,
      FETXC_SEND_K,
      FETXC_DATA,
      FETXC_SEND_T,
      FETXC_SEND_R
   } fetxc_state_t;
   typedef logic [4:0] fetxc_cg_t;
   typedef enum logic [1:0] {
      FETXC_MLT_ZERO_UP,
      FETXC_MLT_PLUS,
      FETXC_MLT_ZERO_DN,
      FETXC_MLT_MINUS
   } fetxc_mlt_t;
endpackage : fetxc_pkg

//--- rtl/fetxc_regs.svh
// Constants for the fast ethernet transmit line coder.
`ifndef FETXC_REGS_SVH
`define FETXC_REGS_SVH
`define FETXC_CG_J      5'h18
`define FETXC_CG_K      5'h11
`define FETXC_CG_T      5'h0d
`define FETXC_CG_R      5'h07
`define FETXC_CG_IDLE   5'h1f
`define FETXC_CG_HALT   5'h04
`define FETXC_LFSR_SEED 11'h7ff
`define FETXC_LFSR_ZERO 11'h000
`define FETXC_TAP_A     10
`define FETXC_TAP_B     8
`define FETXC_BIT_LAST  3'h4
`define FETXC_BIT_FIRST 3'h0
`endif

//--- rtl/fetxc_scrambler.sv
// Free-running side-stream 11-bit scrambler applied to the serial code-group stream.
`timescale 1ns/100ps
`include "fetxc_regs.svh"
module fetxc_scrambler #(
   parameter int WIDTH = 11
) (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic bypass,
   input  wire logic din,
   output logic      dout
);
   import fetxc_pkg::*;
   logic [WIDTH-1:0] lfsr_q;
   logic [WIDTH-1:0] lfsr_d;
   logic             key;
   logic             dout_d;
   always_comb begin
      key    = lfsr_q[`FETXC_TAP_A] ^ lfsr_q[`FETXC_TAP_B];
      lfsr_d = {lfsr_q[WIDTH-2:0], key};
      // An all-zero register would lock the key at zero forever, so it is reseeded.
      if (lfsr_d == `FETXC_LFSR_ZERO) begin
         lfsr_d = `FETXC_LFSR_SEED;
      end
      dout_d = bypass ? din : (din ^ key);
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         lfsr_q <= `FETXC_LFSR_SEED;
         dout   <= 1'b0;
      end else begin
         lfsr_q <= lfsr_d;
         dout   <= dout_d;
      end
   end
   chk_lfsr_nonzero: assert property (@(posedge mclk) disable iff (!nrst)
      lfsr_q != `FETXC_LFSR_ZERO) else $error("scrambler register reached zero");
   chk_scr_xor: assert property (@(posedge mclk) disable iff (!nrst)
      nrst && !bypass |=> dout == ($past(din) ^ $past(key)))
      else $error("scramble xor wrong");
endmodule : fetxc_scrambler
